/* File: core/ism_defs.vh */
// constants for the two-wire serial memory command slave
`ifndef ISM_DEFS_VH
`define ISM_DEFS_VH
`define ISM_ADDR_W      11
`define ISM_MEM_DEPTH   2048
`define ISM_TYPE_W      4
`define ISM_TYPE_CODE   4'h5
`define ISM_DIR_WRITE   1'b0
`define ISM_DIR_READ    1'b1
`define ISM_ADDR_LAST   11'h7ff
`define ISM_ADDR_FIRST  11'h000
`define ISM_BIT_LAST    4'h7
`define ISM_ACK_SLOT    4'h8
`endif

/* File: core/ism_pin_sync.v */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module ism_pin_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire sys_clk,
    input  wire nrst,
    input  wire clk_en,
    input  wire pin_in,
    output reg  level_ff
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    // s1 feeds only s2; level moves once s2 and s3 agree
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff    <= RST_VAL;
            s2_ff    <= RST_VAL;
            s3_ff    <= RST_VAL;
            level_ff <= RST_VAL;
        end else if (clk_en) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
        end
    end
endmodule

/* File: core/ism_slave.v */
// two-wire serial memory slave: command layer and 2048x8 array
`timescale 1ns/100ps
`include "ism_defs.vh"
// frame handling overview
// - bus pins pass three flops; an edge counts once two agree
// - scl and sda share one delay, so their order is kept
// - start: sda falls while scl high; any partial byte dropped
// - stop: sda rises while scl high; back to idle, flags cleared
// - first scl fall after a start carries no bit and is skipped
// - address word: four type bits, three upper bits, direction
// - type mismatch: no acknowledge, idle until the next start
// - write frame: low address byte, then data bytes
// - each received byte acknowledged on the ninth clock
// - data byte stored as its eighth bit is sampled
// - write protect latched at start, steady for the frame
// - protected byte: acknowledged, address advanced, data dropped
// - read frame: first byte fetched at end of the ack slot
// - after a set frame the set address is read as is
// - otherwise the byte after the last access is read
// - master ack: next byte from the next address
// - master nack: bus released, idle until the next start; busy held until stop
// - addresses wrap from the last location to zero
//
// address buffer
// - holds the last location touched by a data byte or read byte
// - a set frame leaves a pending address, marked fresh
// - fresh is cleared by the first data byte or read byte
// - upper bits of a read word replace the buffered ones
//
// timing
// - pin change to internal event: about four clocks
// - outgoing data moves about five clocks after scl falls
// - scl low phase must exceed that, or data moves late
// - sda only ever pulled low; high comes from the pull-up
//
// limitations
// - array and address buffer have no reset by design
// - a current read before any access gives an unknown byte
// - no clock stretching; the master sets the pace
// - clock enable low freezes the whole slave, pins too
// - a stop in the middle of a byte drops that byte
module ism_slave #(
    parameter ADDR_W    = `ISM_ADDR_W,
    parameter MEM_DEPTH = `ISM_MEM_DEPTH
) (
    input  wire sys_clk,
    input  wire nrst,
    input  wire clk_en,
    input  wire scl_in,
    input  wire sda_in,
    input  wire wp_in,
    output reg  sda_out_ff,
    output reg  sda_oe_ff,
    output reg  busy_ff,
    output reg  wr_blocked_ff
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_DEV   = 3'h1;
    localparam ST_ADDR  = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_RACK  = 3'h5;

    reg [7:0] mem [0:MEM_DEPTH-1];

    wire             scl_s;
    wire             sda_s;
    wire             wp_s;
    reg              scl_d_ff;
    reg              sda_d_ff;
    reg  [2:0]       state_ff;
    reg  [3:0]       bit_ff;
    reg  [7:0]       shift_ff;
    reg  [ADDR_W-1:0] addr_ff;
    reg              ack_ff;
    reg              wp_frame_ff;
    reg  [7:0]       tx_ff;
    reg              armed_ff;
    reg              fresh_ff;
    wire [ADDR_W-1:0] tgt_addr;
    wire             rd_open;

    // address step with wrap from last location to zero
    function [ADDR_W-1:0] addr_inc;
        input [ADDR_W-1:0] a;
        begin
            addr_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // byte left in the shifter once its msb has gone out
    function [7:0] tx_load;
        input [7:0] b;
        begin
            tx_load = {b[6:0], 1'b0};
        end
    endfunction

    // open drain: a zero bit pulls, a one bit releases
    function pulls_low;
        input [7:0] b;
        begin
            pulls_low = ~b[7];
        end
    endfunction

    // scl and sda idle high; an open wp pin idles low
    ism_pin_sync #(.RST_VAL(1'b1)) u_scl (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .pin_in   (scl_in),
        .level_ff (scl_s)
    );
    ism_pin_sync #(.RST_VAL(1'b1)) u_sda (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .pin_in   (sda_in),
        .level_ff (sda_s)
    );
    ism_pin_sync #(.RST_VAL(1'b0)) u_wp (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .pin_in   (wp_in),
        .level_ff (wp_s)
    );

    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    // sda edges while scl high are bus conditions
    wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire [7:0] shift_nx = {shift_ff[6:0], sda_s};

    // pending set address is used as is, else the one after the last access
    assign tgt_addr = fresh_ff ? addr_ff : addr_inc(addr_ff);
    // read word acknowledged: first read byte is fetched here
    assign rd_open  = state_ff == ST_DEV && scl_fall && armed_ff && bit_ff == `ISM_ACK_SLOT
                      && shift_ff[0] == `ISM_DIR_READ;

    // fresh marks an address set but not yet used by a data byte or read byte
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fresh_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == ST_ADDR && scl_rise && bit_ff == `ISM_BIT_LAST) begin
                fresh_ff <= 1'b1;
            end else if (state_ff == ST_WDATA && scl_rise && bit_ff == `ISM_BIT_LAST) begin
                fresh_ff <= 1'b0;
            end else if (rd_open) begin
                fresh_ff <= 1'b0;
            end
        end
    end

    // edge history
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else if (clk_en) begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // array port, written only on a completed unprotected data byte
    always @(posedge sys_clk) begin
        if (clk_en && state_ff == ST_WDATA && scl_rise && bit_ff == `ISM_BIT_LAST
            && !wp_frame_ff) begin
            mem[tgt_addr] <= shift_nx;
        end
    end

    // address buffer has no reset: undefined until first access
    always @(posedge sys_clk) begin
        if (clk_en) begin
            if (state_ff == ST_DEV && scl_rise && bit_ff == `ISM_BIT_LAST
                && shift_ff[6:3] == `ISM_TYPE_CODE) begin
                addr_ff[ADDR_W-1:8] <= shift_ff[2:0];
            end else if (state_ff == ST_ADDR && scl_rise && bit_ff == `ISM_BIT_LAST) begin
                addr_ff[7:0] <= shift_nx;
            end else if (state_ff == ST_WDATA && scl_rise && bit_ff == `ISM_BIT_LAST) begin
                // protected bytes advance too, so a later read lines up
                addr_ff <= tgt_addr;
            end else if (rd_open) begin
                addr_ff <= tgt_addr;
            end else if (state_ff == ST_RACK && scl_fall && ack_ff) begin
                addr_ff <= addr_inc(addr_ff);
            end
        end
    end

    // protocol sequencer
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff      <= ST_IDLE;
            bit_ff        <= 4'h0;
            shift_ff      <= 8'h00;
            ack_ff        <= 1'b0;
            armed_ff      <= 1'b0;
            wp_frame_ff   <= 1'b0;
            tx_ff         <= 8'h00;
            sda_out_ff    <= 1'b1;
            sda_oe_ff     <= 1'b0;
            busy_ff       <= 1'b0;
            wr_blocked_ff <= 1'b0;
        end else if (clk_en) begin
            if (start_c) begin
                // partial byte dropped, fresh address word follows
                state_ff    <= ST_DEV;
                bit_ff      <= 4'h0;
                armed_ff    <= 1'b0; // the fall ending the start is no bit
                sda_oe_ff   <= 1'b0;
                sda_out_ff  <= 1'b1;
                busy_ff     <= 1'b1;
                wp_frame_ff <= wp_s;
            end else if (stop_c) begin
                state_ff      <= ST_IDLE;
                sda_oe_ff     <= 1'b0;
                sda_out_ff    <= 1'b1;
                busy_ff       <= 1'b0;
                wr_blocked_ff <= 1'b0;
            end else begin
                case (state_ff)
                    // receiving: eight bits in, then our acknowledge
                    ST_DEV, ST_ADDR, ST_WDATA: begin
                        if (scl_rise) begin
                            armed_ff <= 1'b1;
                        end
                        if (scl_rise && bit_ff <= `ISM_BIT_LAST) begin
                            shift_ff <= shift_nx;
                        end
                        if (scl_fall && armed_ff) begin
                            if (bit_ff < `ISM_ACK_SLOT) begin
                                bit_ff <= bit_ff + 4'h1;
                                if (bit_ff == `ISM_BIT_LAST) begin
                                    if (state_ff == ST_DEV &&
                                        shift_ff[7:4] != `ISM_TYPE_CODE) begin
                                        state_ff <= ST_IDLE;
                                        busy_ff  <= 1'b0;
                                    end else begin
                                        sda_oe_ff  <= 1'b1;
                                        sda_out_ff <= 1'b0;
                                        if (state_ff == ST_WDATA) begin
                                            wr_blocked_ff <= wp_frame_ff;
                                        end
                                    end
                                end
                            end else begin
                                // end of ack slot: release or begin read data
                                bit_ff <= 4'h0;
                                if (state_ff == ST_DEV && shift_ff[0] == `ISM_DIR_READ) begin
                                    state_ff   <= ST_RDATA;
                                    tx_ff      <= tx_load(mem[tgt_addr]);
                                    sda_oe_ff  <= pulls_low(mem[tgt_addr]);
                                    sda_out_ff <= 1'b0;
                                end else begin
                                    sda_oe_ff  <= 1'b0;
                                    sda_out_ff <= 1'b1;
                                    state_ff   <= (state_ff == ST_DEV) ? ST_ADDR : ST_WDATA;
                                end
                            end
                        end
                    end
                    ST_RDATA: begin
                        // open drain: drive only zeros, change on falling edge
                        if (scl_fall) begin
                            if (bit_ff == `ISM_BIT_LAST) begin
                                state_ff  <= ST_RACK;
                                sda_oe_ff <= 1'b0;
                                bit_ff    <= 4'h0;
                            end else begin
                                sda_oe_ff <= pulls_low(tx_ff);
                                tx_ff     <= {tx_ff[6:0], 1'b0};
                                bit_ff    <= bit_ff + 4'h1;
                            end
                        end
                    end
                    // master answers a read byte: ack continues, nack ends
                    ST_RACK: begin
                        if (scl_rise) begin
                            ack_ff <= ~sda_s;
                        end
                        if (scl_fall) begin
                            if (ack_ff) begin
                                state_ff  <= ST_RDATA;
                                tx_ff     <= tx_load(mem[addr_inc(addr_ff)]);
                                sda_oe_ff <= pulls_low(mem[addr_inc(addr_ff)]);
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

/* File: testbench/ism_slave_properties.sv */
// port assertions for the serial memory slave
`timescale 1ns/100ps
module ism_slave_props (
    input wire sys_clk,
    input wire nrst,
    input wire clk_en,
    input wire scl_in,
    input wire sda_in,
    input wire wp_in,
    input wire sda_out_ff,
    input wire sda_oe_ff,
    input wire busy_ff,
    input wire wr_blocked_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // bus events seen at the pins
    sequence start_s; scl_in && $fell(sda_in); endsequence
    sequence stop_s; scl_in && $rose(sda_in); endsequence
    a_drive_low: assert property (sda_oe_ff |-> !sda_out_ff)
        else $error("data driven high");
    a_oe_in_frame: assert property (sda_oe_ff |-> busy_ff)
        else $error("data driven outside a frame");
    a_oe_scl_low: assert property ($changed(sda_oe_ff) |-> !scl_in)
        else $error("data changed while clock high");
    a_ack_holds: assert property ($rose(sda_oe_ff) |-> sda_oe_ff [*8])
        else $error("acknowledge too short");
    a_blk_needs_wp: assert property ($rose(wr_blocked_ff) |-> wp_in)
        else $error("discard without protect");
    a_blk_idle: assert property (!busy_ff && $past(!busy_ff) |-> !wr_blocked_ff)
        else $error("discard flag left after stop");
    a_start_busy: assert property (start_s |-> ##8 busy_ff)
        else $error("start not seen");
    a_stop_idle: assert property (stop_s |-> ##8 (!busy_ff && !sda_oe_ff))
        else $error("stop not seen");
endmodule
bind ism_slave ism_slave_props u_props (.sys_clk, .nrst, .clk_en, .scl_in, .sda_in,
    .wp_in, .sda_out_ff, .sda_oe_ff, .busy_ff, .wr_blocked_ff);

/* File: testbench/ism_i2c_master.sv */
// two-wire bus master model that drives the serial clock
`timescale 1ns/100ps
module ism_i2c_master #(
    parameter H = 6
) (
    input  wire  sys_clk,
    input  wire  sda_w,
    output logic scl,
    output logic sda_m
);
    // clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task hp;
        repeat (H) @(negedge sys_clk);
    endtask
    // start, or repeated start from clock low
    task start;
        sda_m = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda_m = 1'b0;
        hp;
        scl = 1'b0;
    endtask
    task stop;
        sda_m = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda_m = 1'b1;
        hp;
    endtask
    // eight bits msb first then the answer bit; ai high releases
    task xb(input [7:0] tx, input ai, output [7:0] rx, output ao);
        logic [8:0] s;
        logic [8:0] r;
        s = {tx, ai};
        for (int i = 8; i >= 0; i--) begin
            sda_m = s[i];
            hp;
            scl = 1'b1;
            hp;
            r[i] = sda_w;
            scl = 1'b0;
        end
        {rx, ao} = r;
    endtask
endmodule

/* File: testbench/ism_slave_tb.sv */
// self-checking bench for the serial memory slave
`timescale 1ns/100ps
`include "ism_defs.vh"
module ism_slave_tb;
    logic sys_clk;
    logic nrst;
    logic wp_in;
    logic scl;
    logic sda_m;
    logic sda_w;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic blk;
    int   n_fail;
    int   n_checks;
    // pull-up wire: low whenever either side pulls
    assign sda_w = sda_m & ~sda_oe;
    ism_slave u_ism_slave (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .scl_in(scl),
        .sda_in(sda_w), .wp_in(wp_in), .sda_out_ff(sda_out), .sda_oe_ff(sda_oe),
        .busy_ff(busy), .wr_blocked_ff(blk));
    ism_i2c_master u_ism_i2c_master (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl),
        .sda_m(sda_m));
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task sp;
        u_ism_i2c_master.stop;
    endtask
    task wb(input [7:0] d);
        logic [7:0] r;
        logic a;
        u_ism_i2c_master.xb(d, 1'b1, r, a);
        chk("ack", 8'h00, {7'h0, a});
    endtask
    task rb(input ai, input [7:0] e);
        logic [7:0] r;
        logic a;
        u_ism_i2c_master.xb(8'hff, ai, r, a);
        chk("data", e, r);
    endtask
    task word(input [10:0] a, input d);
        u_ism_i2c_master.start;
        wb({`ISM_TYPE_CODE, a[10:8], d});
    endtask
    task seta(input [10:0] a);
        word(a, `ISM_DIR_WRITE);
        wb(a[7:0]);
    endtask
    task t_page_wrap;
        seta(11'h7fe);
        wb(8'h11);
        wb(8'h22);
        wb(8'h33);
        wb(8'h44);
        sp;
        $display("page write done");
    endtask
    // address set then repeated start; read starts at the set address
    task t_seq_read;
        seta(11'h7fe);
        word(11'h7fe, `ISM_DIR_READ);
        rb(1'b0, 8'h11);
        rb(1'b0, 8'h22);
        rb(1'b0, 8'h33);
        rb(1'b1, 8'h44);
        sp;
        $display("sequential read done");
    endtask
    task t_cur_wrap;
        seta(11'h7fe);
        word(11'h7fe, `ISM_DIR_READ);
        rb(1'b1, 8'h11);
        sp;
        word(11'h7fe, `ISM_DIR_READ);
        rb(1'b1, 8'h22);
        sp;
        word(11'h7ff, `ISM_DIR_READ);
        rb(1'b1, 8'h33);
        sp;
        word(11'h000, `ISM_DIR_READ);
        rb(1'b1, 8'h44);
        sp;
        $display("current read done");
    endtask
    // protect changes only between frames
    task t_wp_block;
        wp_in = 1'b1;
        seta(11'h7fe);
        wb(8'h99);
        chk("blocked", 8'h01, {7'h0, blk});
        sp;
        chk("blocked", 8'h00, {7'h0, blk});
        seta(11'h7fe);
        word(11'h7fe, `ISM_DIR_READ);
        rb(1'b1, 8'h11);
        sp;
        wp_in = 1'b0;
        $display("write protect done");
    endtask
    task t_bad_type;
        logic [7:0] r;
        logic a;
        u_ism_i2c_master.start;
        u_ism_i2c_master.xb(8'h30, 1'b1, r, a);
        chk("nack", 8'h01, {7'h0, a});
        chk("busy", 8'h00, {7'h0, busy});
        sp;
        $display("foreign type done");
    endtask
    task final_report;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // reset, let synchronisers fill, then run the scenarios
    initial begin
        n_fail = 0;
        n_checks = 0;
        nrst = 1'b0;
        wp_in = 1'b0;
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk("idle", 8'h00, {6'h0, busy, sda_oe});
        chk("release", 8'h01, {7'h0, sda_out});
        t_page_wrap;
        t_seq_read;
        t_cur_wrap;
        t_wp_block;
        t_bad_type;
        final_report;
    end
    // about five times the expected run length
    initial begin
        #100000;
        n_fail++;
        final_report;
    end
endmodule
